// ==== common/ota_pkg.sv ====
// Shared constants and types for the overhead test and alignment control block
package ota_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int NCH    = 4;          // Receive/transmit channels
    localparam int THR_W  = 5;          // Alignment threshold width
    localparam int CNT_W  = 4;          // Burst length width
    localparam int BYTE_W = 8;          // Byte width
    localparam int ADR_W  = 8;          // Wishbone byte address width
    localparam int DAT_W  = 32;         // Wishbone data width
    localparam int SEL_W  = 4;          // Wishbone byte selects
    localparam int IDX_W  = 6;          // Register index width

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_MIN  = 6'h0a;  // Minimum fill threshold
    localparam logic [IDX_W-1:0] IDX_MAX  = 6'h0b;  // Maximum fill threshold
    localparam logic [IDX_W-1:0] IDX_CTL  = 6'h0c;  // Count, loopback, parity
    localparam logic [IDX_W-1:0] IDX_A1   = 6'h0d;  // First framing substitute
    localparam logic [IDX_W-1:0] IDX_A2   = 6'h0e;  // Second framing substitute
    localparam logic [IDX_W-1:0] IDX_STAT = 6'h14;  // Threshold error flags

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_CNT_LSB  = 0;    // Burst length field low bit
    localparam int CTL_LOOP_BIT = 4;    // Line loopback enable
    localparam int CTL_PAR_BIT  = 5;    // Odd parity select
    localparam int CTL_W        = 6;    // Implemented control bits

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [THR_W-1:0]  MIN_RST = 5'h02;
    localparam logic [THR_W-1:0]  MAX_RST = 5'h15;
    localparam logic [CTL_W-1:0]  CTL_RST = 6'h00;
    localparam logic [BYTE_W-1:0] A1_RST  = 8'h00;
    localparam logic [BYTE_W-1:0] A2_RST  = 8'h00;

    // ------------------------------------------------------------
    // Burst engine states, Gray ordered
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OTA_IDLE  = 2'h0,
        OTA_BURST = 2'h1
    } ota_burst_t;

    // Fill level outside the window set by the two thresholds
    function automatic logic ota_viol(input logic [THR_W-1:0] fill,
                                      input logic [THR_W-1:0] lo,
                                      input logic [THR_W-1:0] hi);
        ota_viol = (fill < lo) || (fill > hi);
    endfunction : ota_viol

endpackage : ota_pkg

// ==== rtl/ota_burst.sv ====
// Per-channel framing byte corruption burst engine
`timescale 1ns/1ns
module ota_burst
    import ota_pkg::*;
(
    input  wire logic                    clk_i,      // System clock
    input  wire logic                    rst_i,      // Synchronous reset
    input  wire logic                    ce_i,       // Clock enable
    input  wire logic                    cmd_i,      // Corruption command bit
    input  wire logic                    frame_i,    // Transmit frame start
    input  wire logic [ota_pkg::CNT_W-1:0] count_i,  // Frames to corrupt
    output logic                         corrupt_o   // Corrupt this frame
);
    import ota_pkg::*;

    logic             cmd_q;        // Command from last cycle
    ota_burst_t       state;        // Engine state
    logic [CNT_W-1:0] left;         // Frames still to corrupt
    wire              rise = cmd_i & ~cmd_q;    // Zero to one edge

    // ------------------------------------------------------------
    // Burst sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_q     <= 1'b0;
            state     <= OTA_IDLE;
            left      <= '0;
            corrupt_o <= 1'b0;
        end else if (ce_i) begin
            cmd_q <= cmd_i;
            if (rise) begin
                // New burst armed; a held level never re-arms
                left  <= count_i;
                state <= (count_i != '0) ? OTA_BURST : OTA_IDLE;
            end else if (frame_i) begin
                case (state)
                    OTA_BURST: begin
                        corrupt_o <= 1'b1;
                        left      <= left - 1'b1;
                        if (left == 4'h1) begin
                            state <= OTA_IDLE;
                        end
                    end
                    default: begin
                        corrupt_o <= 1'b0;          // Normal framing again
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    held_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && cmd_q && cmd_i && state == OTA_IDLE |=> state == OTA_IDLE)
        else $error("held command restarted a burst");

    burst_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && frame_i && !rise && state == OTA_BURST
        |=> corrupt_o && left == $past(left) - 4'h1)
        else $error("burst frame not counted");

    idle_clean_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && frame_i && !rise && state == OTA_IDLE |=> !corrupt_o)
        else $error("corruption outside a burst");

endmodule : ota_burst

// ==== rtl/ota_ctrl.sv ====
// Overhead test and alignment control registers with their datapath
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
module ota_ctrl
    import ota_pkg::*;
(
    input  wire logic                                          clk_i,
    input  wire logic                                          rst_i,
    input  wire logic                                          ce_i,
    // Wishbone classic slave
    input  wire logic                                          wb_cyc_i,
    input  wire logic                                          wb_stb_i,
    input  wire logic                                          wb_we_i,
    input  wire logic [ota_pkg::ADR_W-1:0]                     wb_adr_i,
    input  wire logic [ota_pkg::SEL_W-1:0]                     wb_sel_i,
    input  wire logic [ota_pkg::DAT_W-1:0]                     wb_dat_i,
    output logic      [ota_pkg::DAT_W-1:0]                     wb_dat_o,
    output logic                                               wb_ack_o,
    // Receive alignment FIFO fill levels
    input  wire logic [ota_pkg::NCH-1:0][ota_pkg::THR_W-1:0]   rx_fill_i,
    output logic      [ota_pkg::NCH-1:0]                       thr_event_o,
    output logic      [ota_pkg::NCH-1:0]                       thr_flag_o,
    // Transmit framing corruption
    input  wire logic [ota_pkg::NCH-1:0]                       fe_cmd_i,
    input  wire logic                                          tx_frame_i,
    input  wire logic                                          tx_a1_i,
    input  wire logic                                          tx_a2_i,
    // Byte datapath
    input  wire logic [ota_pkg::NCH-1:0][ota_pkg::BYTE_W-1:0]  rx_data_i,
    input  wire logic [ota_pkg::NCH-1:0][ota_pkg::BYTE_W-1:0]  tx_data_i,
    output logic      [ota_pkg::NCH-1:0][ota_pkg::BYTE_W-1:0]  tx_data_o,
    output logic      [ota_pkg::NCH-1:0]                       tx_par_o,
    output logic                                               loop_o,
    output logic                                               odd_par_o
);
    import ota_pkg::*;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [THR_W-1:0]  thr_min;     // Minimum fill threshold
    logic [THR_W-1:0]  thr_max;     // Maximum fill threshold
    logic [CTL_W-1:0]  ctl;         // Count, loopback, parity
    logic [BYTE_W-1:0] a1_sub;      // First framing substitute
    logic [BYTE_W-1:0] a2_sub;      // Second framing substitute
    logic [NCH-1:0]    viol_q;      // Violation seen last cycle
    logic [NCH-1:0]    corrupt;     // Per-channel burst in force

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire              req    = wb_cyc_i & wb_stb_i;         // Live request
    wire              wr_go  = req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire [IDX_W-1:0]  idx    = wb_adr_i[ADR_W-1:2];         // Word index
    wire              hit_min  = (idx == IDX_MIN);
    wire              hit_max  = (idx == IDX_MAX);
    wire              hit_ctl  = (idx == IDX_CTL);
    wire              hit_a1   = (idx == IDX_A1);
    wire              hit_a2   = (idx == IDX_A2);
    wire              hit_stat = (idx == IDX_STAT);
    wire [BYTE_W-1:0] wbyte  = wb_dat_i[BYTE_W-1:0];        // Low lane

    // Read selection; unmapped words read as zero
    wire [BYTE_W-1:0] rd_byte =
        hit_min  ? {3'h0, thr_min} :
        hit_max  ? {3'h0, thr_max} :
        hit_ctl  ? {2'h0, ctl}     :
        hit_a1   ? a1_sub          :
        hit_a2   ? a2_sub          :
        hit_stat ? {4'h0, thr_flag_o} : 8'h00;

    // Control fields
    wire [CNT_W-1:0]  burst_cnt = ctl[CTL_CNT_LSB +: CNT_W];
    wire              loop_en   = ctl[CTL_LOOP_BIT];
    wire              odd_en    = ctl[CTL_PAR_BIT];

    // Flag clear mask, write one to clear
    wire [NCH-1:0]    flag_clr  = (wr_go && hit_stat) ? wbyte[NCH-1:0] : '0;

    // ------------------------------------------------------------
    // Bus answer: ack one cycle after request, dropped next cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= {24'h0, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // Register writes at the acknowledging edge
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_min <= MIN_RST;
            thr_max <= MAX_RST;
            ctl     <= CTL_RST;
            a1_sub  <= A1_RST;
            a2_sub  <= A2_RST;
        end else if (ce_i && wr_go) begin
            // Range 0-23 / 0-22 is software's duty; stored as written
            if (hit_min) begin
                thr_min <= wbyte[THR_W-1:0];
            end
            if (hit_max) begin
                thr_max <= wbyte[THR_W-1:0];
            end
            if (hit_ctl) begin
                ctl <= wbyte[CTL_W-1:0];
            end
            if (hit_a1) begin
                a1_sub <= wbyte;
            end
            if (hit_a2) begin
                a2_sub <= wbyte;
            end
        end
    end

    // ------------------------------------------------------------
    // Alignment threshold monitor
    // ------------------------------------------------------------
    logic [NCH-1:0] viol;           // Channel outside window now
    wire  [NCH-1:0] viol_rise = viol & ~viol_q;     // New violation

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_thr
            // Same shared pair for every channel
            assign viol[c] = ota_viol(rx_fill_i[c], thr_min, thr_max);
        end
    endgenerate

    // Event pulse and sticky flag; a new event beats a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            viol_q      <= '0;
            thr_event_o <= '0;
            thr_flag_o  <= '0;
        end else if (ce_i) begin
            viol_q      <= viol;
            thr_event_o <= viol_rise;
            thr_flag_o  <= (thr_flag_o & ~flag_clr) | viol_rise;
        end
    end

    // ------------------------------------------------------------
    // Corruption burst engines
    // ------------------------------------------------------------
    generate
        for (c = 0; c < NCH; c++) begin : g_burst
            // Shared count with the channel's own command
            ota_burst u_burst (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .ce_i      (ce_i),
                .cmd_i     (fe_cmd_i[c]),
                .frame_i   (tx_frame_i),
                .count_i   (burst_cnt),
                .corrupt_o (corrupt[c])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Transmit byte selection
    // ------------------------------------------------------------
    logic [NCH-1:0][BYTE_W-1:0] next_tx;    // Byte to send
    logic [NCH-1:0]             next_par;   // Its parity bit
    logic [NCH-1:0][BYTE_W-1:0] src_tx;     // Loopback or normal

    generate
        for (c = 0; c < NCH; c++) begin : g_tx
            // Receive data turned round on the logic side
            assign src_tx[c]  = loop_en ? rx_data_i[c] : tx_data_i[c];
            // Substitute framing bytes while the burst lasts
            assign next_tx[c] =
                (corrupt[c] && tx_a1_i) ? a1_sub :
                (corrupt[c] && tx_a2_i) ? a2_sub : src_tx[c];
            // Even sense when control is zero, odd when one
            assign next_par[c] = (^next_tx[c]) ^ odd_en;
        end
    endgenerate

    // Registered datapath and mode outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_data_o <= '0;
            tx_par_o  <= '0;
            loop_o    <= 1'b0;
            odd_par_o <= 1'b0;
        end else if (ce_i) begin
            tx_data_o <= next_tx;
            tx_par_o  <= next_par;
            loop_o    <= loop_en;
            odd_par_o <= odd_en;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held two cycles");

    reset_val_a: assert property (@(posedge clk_i)
        rst_i |=> thr_min == MIN_RST && thr_max == MAX_RST && ctl == CTL_RST)
        else $error("threshold reset value wrong");

    thr_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && viol[0] && !viol_q[0] |=> thr_flag_o[0] && thr_event_o[0])
        else $error("threshold violation not latched");

    flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && thr_flag_o[1] && !flag_clr[1] |=> thr_flag_o[1])
        else $error("threshold flag lost");

    shared_thr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_fill_i[2] == rx_fill_i[3] |-> viol[2] == viol[3])
        else $error("channels judged apart");

    loop_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && loop_en && !corrupt[0] |=> tx_data_o[0] == $past(rx_data_i[0]))
        else $error("loopback data not routed");

    sub_byte_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && corrupt[1] && tx_a1_i |=> tx_data_o[1] == $past(a1_sub))
        else $error("substitute byte missing");

    parity_sense_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> tx_par_o[0] == ((^tx_data_o[0]) ^ odd_par_o))
        else $error("parity sense wrong");

endmodule : ota_ctrl

// ==== bench/ota_ctrl_tb_top.sv ====
// Self-checking bench for the overhead test and alignment control block
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH at %0t got %h expected %h", $time, (g), (e)); end end
module ota_ctrl_tb_top;
    import ota_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    logic                   clk_i = 1'b0;     // System clock
    logic                   rst_i = 1'b1;     // Synchronous reset
    logic                   ce_i  = 1'b1;     // Clock enable
    logic                   cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0]             adr = 8'h00;      // Byte address
    logic [3:0]             sel = 4'h0;       // Byte selects
    logic [31:0]            wdat = '0, dat_o, rdat;
    logic [3:0][4:0]        fill;             // FIFO fill levels
    logic [3:0]             ev, fl, par, cmd = 4'h0;
    logic                   frame = 1'b0, a1 = 1'b0, a2 = 1'b0, loop_o, odd_o;
    logic [3:0][7:0]        rxd = '0, txd = '0, txo;
    logic [7:0]             ctls = 8'h00, a1s = 8'h00, a2s = 8'h00; // Register shadows
    int                     seed = 40985, n_errors = 0, compares = 0, ncyc = 0;
    initial fill = {4{5'd10}};

    ota_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_fill_i(fill), .thr_event_o(ev),
        .thr_flag_o(fl), .fe_cmd_i(cmd), .tx_frame_i(frame), .tx_a1_i(a1),
        .tx_a2_i(a2), .rx_data_i(rxd), .tx_data_i(txd), .tx_data_o(txo),
        .tx_par_o(par), .loop_o(loop_o), .odd_par_o(odd_o));

    // Clock generator and hang guard
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        ncyc++;
        if (ncyc == 5000) begin     // Far beyond the planned run
            n_errors++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Expected transmit byte for one channel
    function automatic logic [7:0] exp_byte(input logic c, m1, m2, input logic [7:0] r, t);
        exp_byte = (c && m1) ? a1s : (c && m2) ? a2s : ctls[4] ? r : t;
    endfunction : exp_byte

    // Classic single Wishbone cycle, waits for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wb

    // One byte cycle on every channel, checked one cycle later
    task automatic tx_byte(input logic m1, m2, input logic [3:0] cm);
        logic [3:0][7:0] r, t, e;
        r = $random(seed);
        t = $random(seed);
        @(posedge clk_i);
        a1 <= m1; a2 <= m2; rxd <= r; txd <= t;
        for (int c = 0; c < 4; c++) e[c] = exp_byte(cm[c], m1, m2, r[c], t[c]);
        @(posedge clk_i); #1;
        for (int c = 0; c < 4; c++) begin
            `CHK(txo[c], e[c])
            `CHK(par[c], ^e[c] ^ ctls[5])
        end
    endtask : tx_byte

    // Verdict and end of run
    task automatic end_of_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        static logic [7:0] ra[5] = '{8'h28, 8'h2c, 8'h30, 8'h34, 8'h38};
        static logic [7:0] rv[5] = '{8'h02, 8'h15, 8'h00, 8'h00, 8'h00};
        static int lim[5] = '{24, 23, 64, 256, 256};
        static int cnts[3] = '{2, 0, 15};
        logic [7:0] v, lo, hi, fv[4];
        logic [3:0][7:0] hold;      // Transmit bytes before the freeze
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, random write, ignored byte-select write, read back
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, ra[i], 4'hf, 0, rdat);
            `CHK(rdat, {24'h0, rv[i]})
            v = 8'($unsigned($random(seed)) % lim[i]);
            wb(1'b1, ra[i], 4'hf, {24'h0, v}, rdat);
            wb(1'b1, ra[i], 4'he, {24'h0, v ^ 8'h01}, rdat);
            wb(1'b0, ra[i], 4'hf, 0, rdat);
            `CHK(rdat, {24'h0, v})
        end
        wb(1'b1, 8'h3c, 4'hf, 32'hff, rdat);    // Unmapped place
        wb(1'b0, 8'h3c, 4'hf, 0, rdat);
        `CHK(rdat, 32'h0)
        // Threshold window shared by all channels, boundaries included
        lo = 8'(1 + $unsigned($random(seed)) % 8);  // Software keeps range
        hi = 8'(14 + $unsigned($random(seed)) % 8);
        wb(1'b1, 8'h28, 4'hf, {24'h0, lo}, rdat);
        wb(1'b1, 8'h2c, 4'hf, {24'h0, hi}, rdat);
        wb(1'b1, 8'h50, 4'hf, 32'hf, rdat);     // Drop flags left by random thresholds
        fv = '{lo, hi, lo - 8'd1, hi + 8'd1};
        for (int ch = 0; ch < 4; ch++) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge clk_i) fill[ch] <= fv[k][4:0];
                @(posedge clk_i); #1;
                `CHK(ev, (k >= 2) ? (4'h1 << ch) : 4'h0)
                `CHK(fl, ((k >= 2) ? (4'h1 << ch) : 4'h0) | ((4'h1 << ch) - 4'h1))
                @(posedge clk_i); #1;
                `CHK(ev, 4'h0)
                @(posedge clk_i) fill[ch] <= 5'd10;
            end
        end
        wb(1'b0, 8'h50, 4'hf, 0, rdat);
        `CHK(rdat, 32'hf)
        wb(1'b1, 8'h50, 4'hf, 32'hf, rdat);     // Clear all flags
        wb(1'b0, 8'h50, 4'hf, 0, rdat);
        `CHK(rdat, 32'h0)
        // Corruption bursts of several lengths on different channels
        a1s = 8'($random(seed));
        a2s = 8'($random(seed));
        wb(1'b1, 8'h34, 4'hf, {24'h0, a1s}, rdat);
        wb(1'b1, 8'h38, 4'hf, {24'h0, a2s}, rdat);
        for (int it = 0; it < 3; it++) begin
            ctls = 8'(cnts[it]) | ((it == 2) ? 8'h20 : 8'h00);
            wb(1'b1, 8'h30, 4'hf, {24'h0, ctls}, rdat);
            @(posedge clk_i) cmd <= 4'h0;       // Low before a new burst
            @(posedge clk_i) cmd[it] <= 1'b1;   // Rising edge arms
            for (int f = 0; f <= cnts[it] + 1; f++) begin
                @(posedge clk_i) frame <= 1'b1;
                @(posedge clk_i) frame <= 1'b0;
                tx_byte(1'b1, 1'b0, (f < cnts[it]) ? (4'h1 << it) : 4'h0);
                tx_byte(1'b0, 1'b1, (f < cnts[it]) ? (4'h1 << it) : 4'h0);
                tx_byte(1'b0, 1'b0, 4'h0);
            end
            @(posedge clk_i) cmd <= 4'h0;
        end
        // Loopback and parity sense in all four combinations
        for (int c = 0; c < 4; c++) begin
            ctls = 8'(c << 4) | 8'h03;
            wb(1'b1, 8'h30, 4'hf, {24'h0, ctls}, rdat);
            tx_byte(1'b1, 1'b0, 4'h0);
            `CHK(loop_o, ctls[4])
            `CHK(odd_o, ctls[5])
            repeat (3) tx_byte(1'b0, 1'b0, 4'h0);
        end
        // Clock enable low: datapath and flags stand still
        @(posedge clk_i) ce_i <= 1'b0;
        rxd     <= ~rxd;
        txd     <= ~txd;
        fill[0] <= 5'd0;            // Below the minimum lo written above
        #1 hold = txo;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK(txo, hold)
        `CHK(ev | fl, 4'h0)
        @(posedge clk_i) ce_i <= 1'b1;
        @(posedge clk_i); #1;
        `CHK(ev, 4'h1)
        `CHK(fl, 4'h1)
        end_of_test();
    end
endmodule : ota_ctrl_tb_top
